// [include/dpo_pkg.sv]
// Shared constants for the dual pixel output formatter
package dpo_pkg;

	// ------------------------------------------------------------
	// Data path widths and buffering
	// ------------------------------------------------------------
	localparam int PIX_W      = 24;                // One pixel, up to 24 bits
	localparam int FIFO_DEPTH = 16;                // Words ahead of the formatter
	localparam int LVL_W      = $clog2(FIFO_DEPTH + 1);

	// ------------------------------------------------------------
	// Timing: ref_clk cycles per output clock period
	// ------------------------------------------------------------
	localparam int REF_CLK_MHZ    = 40;
	localparam int ONE_PIX_PERIOD = 4;                   // One pixel per clock
	localparam int TWO_PIX_PERIOD = 2 * ONE_PIX_PERIOD;  // Half the clock rate
	localparam int OUT_ONE_MHZ    = REF_CLK_MHZ / ONE_PIX_PERIOD;
	localparam int OUT_TWO_MHZ    = REF_CLK_MHZ / TWO_PIX_PERIOD;

	// ------------------------------------------------------------
	// Phase slots within one output period
	// ------------------------------------------------------------
	localparam logic [2:0] ONE_LAST    = 3'(ONE_PIX_PERIOD - 1);
	localparam logic [2:0] TWO_LAST    = 3'(TWO_PIX_PERIOD - 1);
	localparam logic [2:0] ONE_HALF    = 3'(ONE_PIX_PERIOD / 2);
	localparam logic [2:0] TWO_HALF    = 3'(TWO_PIX_PERIOD / 2);
	localparam logic [2:0] TWO_QUARTER = 3'(TWO_PIX_PERIOD / 4);
	localparam logic [2:0] ONE_POP     = 3'(ONE_PIX_PERIOD / 4 + 1);
	localparam logic [2:0] TWO_POP     = 3'(TWO_PIX_PERIOD / 4 + 1);
	localparam logic [2:0] PHASE_RST   = 3'h0;

endpackage

// [rtl/dpo_fifo.sv]
// Parameterised pixel FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dpo_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic                       ref_clk,
	input  wire logic                       nrst,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [CW-1:0]               count;
		logic                        not_full;
	} dpo_fifo_st_t;

	dpo_fifo_st_t st;
	dpo_fifo_st_t next_st;
	logic         do_wr;
	logic         do_rd;

	// ------------------------------------------------------------
	// Pointer and count update
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		do_wr   = in_valid && st.not_full;
		do_rd   = out_ready && (st.count != '0);
		if (do_wr) begin
			next_st.mem[st.wr_ptr] = in_data;
			next_st.wr_ptr         = PW'(st.wr_ptr + 1'b1);
		end
		if (do_rd) begin
			next_st.rd_ptr = PW'(st.rd_ptr + 1'b1);
		end
		next_st.count    = CW'(st.count + CW'(do_wr) - CW'(do_rd));
		// Registered so in_ready leaves straight from a flop
		next_st.not_full = (next_st.count != CW'(DEPTH));
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st          <= '0;
			st.not_full <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign in_ready  = st.not_full;
	assign out_valid = (st.count != '0);
	assign out_data  = st.mem[st.rd_ptr];
	assign level     = st.count;

endmodule

// [rtl/dpo_formatter.sv]
// Pixel output formatter: one or two pixels per output clock, optional stagger
//
// Notes on behaviour
// - Each output clock period carries one pixel or two pixels, per the selected mode.
// - In two-pixel mode the output clock runs at half the one-pixel rate.
// - Staggering applies only in two-pixel mode and only while the stagger pin is low.
// - With staggering, bus B updates a quarter output period after bus A.
// - Both buses share one output clock, so bus B has a quarter period less setup.
// - In a dual-link pair, two-pixel mode and staggering are withheld.
`timescale 1ns/1ps
module dpo_formatter
	import dpo_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [PIX_W-1:0] in_data,
	input  wire logic             two_pix_sel,
	input  wire logic             half_bus_delay_enable_n,
	input  wire logic             dual_link_sel,
	output logic                  out_clk,
	output logic                  out_de,
	output logic [PIX_W-1:0]      pix_a,
	output logic [PIX_W-1:0]      pix_b
);

	typedef struct packed {
		logic             two_s1;
		logic             two_s2;
		logic             stag_s1;
		logic             stag_s2;
		logic             dual_s1;
		logic             dual_s2;
		logic [2:0]       phase;
		logic             cur_two;
		logic             cur_stag;
		logic [PIX_W-1:0] stg_a;
		logic [PIX_W-1:0] stg_b;
		logic             stg_ok;
		logic             pend_b;
		logic             out_clk;
		logic             de;
		logic [PIX_W-1:0] pix_a;
		logic [PIX_W-1:0] pix_b;
	} dpo_state_t;

	dpo_state_t       st;
	dpo_state_t       next_st;
	logic             fifo_valid;
	logic             fifo_pop;
	logic [PIX_W-1:0] fifo_data;
	logic [LVL_W-1:0] fifo_level;

	// ------------------------------------------------------------
	// Phase decoding helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] last_of(input logic two);
		return two ? TWO_LAST : ONE_LAST;
	endfunction

	function automatic logic [2:0] half_of(input logic two);
		return two ? TWO_HALF : ONE_HALF;
	endfunction

	function automatic logic [2:0] pop_of(input logic two);
		return two ? TWO_POP : ONE_POP;
	endfunction

	function automatic logic [2:0] bslot_of(input logic stag);
		return stag ? TWO_QUARTER : PHASE_RST;
	endfunction

	// ------------------------------------------------------------
	// Input buffer
	// ------------------------------------------------------------
	dpo_fifo #(
		.WIDTH (PIX_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   (in_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data),
		.level     (fifo_level)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_st  = st;
		fifo_pop = 1'b0;
		// Pin synchronisers; only stage 2 is used by logic
		next_st.two_s1  = two_pix_sel;
		next_st.two_s2  = st.two_s1;
		next_st.stag_s1 = half_bus_delay_enable_n;
		next_st.stag_s2 = st.stag_s1;
		next_st.dual_s1 = dual_link_sel;
		next_st.dual_s2 = st.dual_s1;

		// Output clock divider; mode only changes on a period boundary
		next_st.phase = (st.phase == last_of(st.cur_two)) ? PHASE_RST : 3'(st.phase + 1'b1);
		if (next_st.phase == PHASE_RST) begin
			next_st.cur_two  = st.two_s2 && !st.dual_s2;
			next_st.cur_stag = st.two_s2 && !st.dual_s2 && !st.stag_s2;
		end
		// Clock rises mid-period so data has half a period of setup, staggered bus B a quarter
		next_st.out_clk = (next_st.phase >= half_of(next_st.cur_two));

		// Bus A and valid change at the period start
		if (next_st.phase == PHASE_RST) begin
			next_st.de = st.stg_ok;
			if (st.stg_ok) begin
				next_st.pix_a = st.stg_a;
			end
		end
		// Bus B at the start, or a quarter period later when staggered
		if (next_st.phase == bslot_of(next_st.cur_stag)) begin
			if ((next_st.phase == PHASE_RST) ? st.stg_ok : st.de) begin
				next_st.pix_b = st.stg_b;
			end
		end

		// Staging fill happens after bus B has been taken
		if (st.phase == pop_of(st.cur_two)) begin
			next_st.stg_ok = 1'b0;
			next_st.pend_b = 1'b0;
			// A pixel pair is only started when both words are present
			if (fifo_level >= (st.cur_two ? LVL_W'(2) : LVL_W'(1))) begin
				fifo_pop       = 1'b1;
				next_st.stg_a  = fifo_data;
				next_st.stg_b  = '0;
				next_st.stg_ok = !st.cur_two;
				next_st.pend_b = st.cur_two;
			end
		end else if (st.pend_b && fifo_valid) begin
			fifo_pop       = 1'b1;
			next_st.stg_b  = fifo_data;
			next_st.stg_ok = 1'b1;
			next_st.pend_b = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st         <= '0;
			st.stag_s1 <= 1'b1;
			st.stag_s2 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops
	assign out_clk = st.out_clk;
	assign out_de  = st.de;
	assign pix_a   = st.pix_a;
	assign pix_b   = st.pix_b;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_two_period;
		(!st.out_clk)[*4] ##1 st.out_clk[*4];
	endsequence

	sequence s_one_period;
		(!st.out_clk)[*2] ##1 st.out_clk[*2];
	endsequence

	a_two_clk_rate: assert property (
		(st.phase == 3'h0 && st.cur_two) |-> s_two_period
	) else $error("two-pixel output clock period wrong");

	a_one_clk_rate: assert property (
		(st.phase == 3'h0 && !st.cur_two) |-> s_one_period
	) else $error("one-pixel output clock period wrong");

	// Bus B keeps its last two-pixel value until a one-pixel pixel is shown,
	// and a pair staged just before a mode switch may still appear once
	a_one_pix_only: assert property (
		(st.phase == 3'h1 && !st.cur_two && st.de && !$past(st.cur_two, 4)) |-> (st.pix_b == '0)
	) else $error("bus B active in one-pixel mode");

	a_stag_needs_two: assert property (
		(st.phase == 3'h0) |-> (st.cur_stag == (st.cur_two && !$past(st.stag_s2)))
	) else $error("stagger state does not follow mode and pin");

	a_stag_quarter_b: assert property (
		($changed(st.pix_b) && st.cur_stag) |-> (st.phase == 3'h2)
	) else $error("staggered bus B not a quarter period late");

	a_b_setup_clk: assert property (
		$changed(st.pix_b) |-> (!st.out_clk ##[2:4] st.out_clk)
	) else $error("bus B changed outside the low clock half");

	a_dual_restrict: assert property (
		(st.phase == 3'h0 && $past(st.dual_s2)) |-> (!st.cur_two && !st.cur_stag)
	) else $error("dual-link pair left two-pixel or stagger on");

	a_plain_together: assert property (
		(($changed(st.pix_a) || $changed(st.pix_b)) && !st.cur_stag) |-> (st.phase == 3'h0)
	) else $error("unstaggered buses did not switch together");

endmodule

// [dv/dpo_panel_model.sv]
// Panel-side receiver model that samples the pixel buses
`timescale 1ns/1ps
module dpo_panel_model
	import dpo_pkg::*;
(
	input wire logic             out_clk,
	input wire logic             out_de,
	input wire logic [PIX_W-1:0] pix_a,
	input wire logic [PIX_W-1:0] pix_b,
	input wire logic             two_mode
);
	// Captured pixels in arrival order
	logic [PIX_W-1:0] rx_q[$];

	// --------------------------------------------------------
	// Capture on the shared output clock
	// --------------------------------------------------------
	// One edge for both buses, so bus B loses setup when staggered
	always @(posedge out_clk) begin
		if (out_de) begin
			rx_q.push_back(pix_a);
			if (two_mode) begin
				rx_q.push_back(pix_b);
			end
		end
	end
endmodule

// [dv/dpo_formatter_tb_top.sv]
// Self-checking bench for the pixel output formatter
`timescale 1ns/1ps
module dpo_formatter_tb_top
	import dpo_pkg::*;
;
	logic             ref_clk = 0;
	logic             nrst = 0;
	logic             in_valid = 0;
	logic             in_ready;
	logic [PIX_W-1:0] in_data = '0;
	logic             two_pix_sel = 0;
	logic             half_bus_delay_enable_n = 1;
	logic             dual_link_sel = 0;
	logic             out_clk;
	logic             out_de;
	logic [PIX_W-1:0] pix_a;
	logic [PIX_W-1:0] pix_b;
	logic             two_e = 0;
	logic             armed = 0;
	logic             prev_clk = 0;
	logic             full_seen = 0;
	logic [PIX_W-1:0] prev_b = '0;
	logic [PIX_W-1:0] exp_q[$];
	logic [2:0]       modes[5] = '{3'h2, 3'h0, 3'h6, 3'h4, 3'h5};
	int               fails = 0;
	int               samples_checked = 0;
	int               cnt = 0;
	int               exp_per = 4;
	int               exp_off = 0;

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	dpo_formatter dpo_formatter_i (.ref_clk(ref_clk), .nrst(nrst), .in_valid(in_valid),
		.in_ready(in_ready), .in_data(in_data), .two_pix_sel(two_pix_sel),
		.half_bus_delay_enable_n(half_bus_delay_enable_n), .dual_link_sel(dual_link_sel),
		.out_clk(out_clk), .out_de(out_de), .pix_a(pix_a), .pix_b(pix_b));

	dpo_panel_model dpo_panel_model_i (.out_clk(out_clk), .out_de(out_de), .pix_a(pix_a),
		.pix_b(pix_b), .two_mode(two_e));

	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Refused words are held unchanged until taken
	task automatic send(int n, bit burst);
		int k;
		bit hold;
		k = 0;
		hold = 0;
		while (k < n) begin
			@(negedge ref_clk);
			if (!hold) begin
				in_valid = burst | 1'($urandom_range(1));
				in_data = PIX_W'($urandom);
			end
			hold = in_valid && !in_ready;
			if (hold) full_seen = 1;
			if (in_valid && in_ready) begin
				exp_q.push_back(in_data);
				k++;
			end
		end
		@(negedge ref_clk) in_valid = 0;
	endtask

	// --------------------------------------------------------
	// Output timing monitor, sampled mid-cycle
	// --------------------------------------------------------
	always @(negedge ref_clk) begin
		if (prev_clk && !out_clk) begin
			if (armed) check(32'(cnt + 1), 32'(exp_per));
			cnt = 0;
		end else cnt++;
		if (armed && pix_b !== prev_b) check(32'(cnt), 32'(exp_off));
		if (armed && !two_e && out_de) check(32'(pix_b), 32'h0);
		prev_clk = out_clk;
		prev_b = pix_b;
	end

	// Hang guard, far above the several hundred cycles needed
	initial begin
		#(25 * 20000);
		fails++;
		results();
	end

	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		void'($urandom(32'hd3120aa2));
		repeat (10) @(negedge ref_clk);
		check(32'({out_clk, out_de, in_ready}), 32'h1);
		nrst = 1;
		// Modes {two, stagger_n, dual}; stagger in two-pixel mode is the burst case
		for (int i = 0; i < 5; i++) begin
			{two_pix_sel, half_bus_delay_enable_n, dual_link_sel} = modes[i];
			two_e = modes[i][2] & !modes[i][0];
			exp_per = two_e ? TWO_PIX_PERIOD : ONE_PIX_PERIOD;
			exp_off = (two_e && !modes[i][1]) ? TWO_PIX_PERIOD / 4 : 0;
			repeat (40) @(negedge ref_clk);
			armed = 1;
			send((i == 3) ? 24 : 10, i == 3);
			for (int w = 0; w < 600 && dpo_panel_model_i.rx_q.size() < exp_q.size(); w++)
				@(negedge ref_clk);
			check(32'(dpo_panel_model_i.rx_q.size()), 32'(exp_q.size()));
			foreach (exp_q[j]) check(32'(dpo_panel_model_i.rx_q[j]), 32'(exp_q[j]));
			exp_q.delete();
			dpo_panel_model_i.rx_q.delete();
			armed = 0;
		end
		check(32'(full_seen), 32'h1);
		// Reset in mid-stream clears the buses
		fork
			send(8, 1);
		join_none
		repeat (6) @(negedge ref_clk);
		nrst = 0;
		@(negedge ref_clk);
		check(32'({out_clk, out_de, in_ready}), 32'h1);
		check(32'(pix_a), 32'h0);
		check(32'(pix_b), 32'h0);
		// Second release: clock restarts low and is high from the half period
		nrst = 1;
		repeat (2) @(negedge ref_clk);
		check(32'({out_clk, out_de}), 32'h2);
		results();
	end
endmodule
